// ---- hdl/serr_cause_defines.svh ----
`ifndef SERR_CAUSE_DEFINES_SVH
`define SERR_CAUSE_DEFINES_SVH

// configuration offsets
`define OFS_SERR_STATUS 8'h68
`define OFS_SERR_MASK 8'h6C
`define OFS_PORT_OPTION 8'h74
`define OFS_RETRY_LIMIT 8'h78

// cause flag field: bits 23:16 of the status word
`define CAUSE_COUNT 8
`define CAUSE_LSB 16
`define CAUSE_MSB 23
`define MASK_COUNT 7

// port option bit positions
`define OPT_PRI_RD_ALIAS 1
`define OPT_PRI_WR_ALIAS 2
`define OPT_SEC_RD_ALIAS 3
`define OPT_SEC_WR_ALIAS 4
`define OPT_LONG_LOCK 9
`define OPT_SEC_HOLD 10
`define OPT_PRI_HOLD 11

// reset values
`define OPT_SEC_HOLD_RST 1'b1
`define OPT_PRI_HOLD_RST 1'b1
`define RETRY_LIMIT_RST 32'h0100_0000
`define RETRY_W 32

`endif

// ---- hdl/serr_cause_pkg.sv ----
package serr_cause_pkg;
    typedef logic [7:0] cfg_addr_t;
    typedef logic [31:0] word_t;

    typedef struct packed {
        logic priHold;
        logic secHold;
        logic longLock;
        logic secWrAlias;
        logic secRdAlias;
        logic priWrAlias;
        logic priRdAlias;
    } option_s;

    // flag index of each cause, bit 16 upward
    typedef enum logic [2:0] {
        CAUSE_ADDR_PARITY = 3'h0,
        CAUSE_POSTED_PARITY = 3'h1,
        CAUSE_POSTED_NODELIVER = 3'h2,
        CAUSE_POSTED_TABORT = 3'h3,
        CAUSE_POSTED_MABORT = 3'h4,
        CAUSE_DELAYED_WR_NODELIVER = 3'h5,
        CAUSE_DELAYED_RD_NODATA = 3'h6,
        CAUSE_MASTER_TIMEOUT = 3'h7
    } cause_e;
endpackage : serr_cause_pkg

// ---- hdl/retry_if.sv ----
`timescale 1ns/1ps
`include "serr_cause_defines.svh"

interface retry_if;
    logic attempt;
    logic progress;
    logic [`RETRY_W-1:0] limit;
    logic limitHit;

    modport counter (input attempt, input progress, input limit, output limitHit);
    modport owner (output attempt, output progress, output limit, input limitHit);
endinterface : retry_if

// ---- hdl/attempt_counter.sv ----
`timescale 1ns/1ps
`include "serr_cause_defines.svh"

module attempt_counter #(
    parameter int CW = `RETRY_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // attempt tracking
    retry_if.counter link
);
    import serr_cause_pkg::*;

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic hit;
    logic next_hit;

    // a limit of zero disables the timeout
    always_comb begin
        next_count = count;
        next_hit = 1'b0;
        if (link.progress) begin
            next_count = '0;
        end else if (link.attempt) begin
            if ((link.limit != '0) && ((count + CW'(1)) >= link.limit)) begin
                next_hit = 1'b1;
                next_count = '0;
            end else begin
                next_count = count + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            hit <= 1'b0;
        end else begin
            count <= next_count;
            hit <= next_hit;
        end
    end

    assign link.limitHit = hit;

    AST_HIT_NEEDS_ATTEMPT: assert property (@(posedge core_clk) disable iff (rst)
        hit |-> $past(link.attempt) && !$past(link.progress))
        else $error("limit hit without a preceding attempt");
endmodule : attempt_counter

// ---- hdl/cause_flag_bank.sv ----
`timescale 1ns/1ps

module cause_flag_bank #(
    parameter int N = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // set and clear
    input wire logic [N-1:0] setBits,
    input wire logic [N-1:0] clearBits,
    // state
    output logic [N-1:0] flags
);
    logic [N-1:0] next_flags;

    // a new event wins over a clear in the same cycle; zero writes change nothing
    always_comb begin
        next_flags = (flags & ~clearBits) | setBits;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    AST_CLEAR_TAKES: assert property (@(posedge core_clk) disable iff (rst)
        (clearBits[0] && !setBits[0]) |=> !flags[0])
        else $error("write of one did not clear flag");
endmodule : cause_flag_bank

// ---- hdl/serr_cause_and_port_options.sv ----
// How it works
// - flag 16 records address parity error cause
// - flag 17 records posted data parity cause
// - flag 18 records posted write non-delivery
// - flag 19 records posted write target abort
// - flag 20 records posted write master abort
// - flag 21 records delayed write non-delivery
// - flag 22 records delayed read no data
// - flag 23 records delayed master timeout
// - option 1 aliases primary read retries
// - option 2 aliases primary write-invalidate retries
// - option 3 aliases secondary read retries
// - option 4 aliases secondary write-invalidate retries
// - option 9 enables long lock requests
// - option 10 secondary master holds request
// - option 11 primary master holds request
// - option bits 0, 8:5 read zero
// - error output needs enable, and a clear mask bit except for master timeout
// - writable retry limit, default two to 24
`timescale 1ns/1ps
`include "serr_cause_defines.svh"

module serr_cause_and_port_options (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // configuration access
    input wire logic cfgWrite,
    input wire logic cfgRead,
    input wire serr_cause_pkg::cfg_addr_t cfgAddr,
    input wire logic [3:0] cfgByteEn,
    input wire serr_cause_pkg::word_t cfgWrData,
    output serr_cause_pkg::word_t cfgRdData,
    output logic cfgRdValid,
    // command register enable
    input wire logic serrEnable,
    // datapath events
    input wire logic evtAddrParityPri,
    input wire logic evtAddrParitySec,
    input wire logic evtPostedDataParity,
    input wire logic evtPostedTargetAbort,
    input wire logic evtPostedMasterAbort,
    input wire logic evtDelayedMasterTimeout,
    // delivery attempts
    input wire logic postedAttempt,
    input wire logic postedDone,
    input wire logic delayedWrAttempt,
    input wire logic delayedWrDone,
    input wire logic delayedRdAttempt,
    input wire logic delayedRdData,
    // error output
    output logic primarySystemErrorOut,
    // port options
    output logic primaryReadAlias,
    output logic primaryWriteAlias,
    output logic secondaryReadAlias,
    output logic secondaryWriteAlias,
    output logic longLockRequest,
    output logic secondaryHoldRequest,
    output logic primaryHoldRequest,
    output serr_cause_pkg::word_t retryLimit
);
    import serr_cause_pkg::*;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    option_s opt;
    option_s next_opt;
    logic [`MASK_COUNT-1:0] serrMask;
    logic [`MASK_COUNT-1:0] next_serrMask;
    word_t next_retryLimit;
    word_t next_cfgRdData;
    logic next_cfgRdValid;
    logic next_serrOut;
    logic [`CAUSE_COUNT-1:0] flags;
    logic [`CAUSE_COUNT-1:0] rawEvt;
    logic [`CAUSE_COUNT-1:0] maskEff;
    logic [`CAUSE_COUNT-1:0] serrCause;
    logic [`CAUSE_COUNT-1:0] clearBits;
    logic statusWr;
    logic maskWr;
    logic optWr;
    logic retryWr;
    word_t readMux;

    retry_if postedIf ();
    retry_if delayedWrIf ();
    retry_if delayedRdIf ();

    assign postedIf.attempt = postedAttempt;
    assign postedIf.progress = postedDone;
    assign postedIf.limit = retryLimit;
    assign delayedWrIf.attempt = delayedWrAttempt;
    assign delayedWrIf.progress = delayedWrDone;
    assign delayedWrIf.limit = retryLimit;
    assign delayedRdIf.attempt = delayedRdAttempt;
    assign delayedRdIf.progress = delayedRdData;
    assign delayedRdIf.limit = retryLimit;

    attempt_counter u_postedCount (
        .core_clk(core_clk),
        .rst(rst),
        .link(postedIf.counter)
    );

    attempt_counter u_delayedWrCount (
        .core_clk(core_clk),
        .rst(rst),
        .link(delayedWrIf.counter)
    );

    attempt_counter u_delayedRdCount (
        .core_clk(core_clk),
        .rst(rst),
        .link(delayedRdIf.counter)
    );

    // write decode
    assign statusWr = cfgWrite && (cfgAddr == `OFS_SERR_STATUS) && cfgByteEn[2];
    assign maskWr = cfgWrite && (cfgAddr == `OFS_SERR_MASK) && cfgByteEn[0];
    assign optWr = cfgWrite && (cfgAddr == `OFS_PORT_OPTION);
    assign retryWr = cfgWrite && (cfgAddr == `OFS_RETRY_LIMIT);

    // cause events, in flag order
    always_comb begin
        rawEvt[CAUSE_ADDR_PARITY] = evtAddrParityPri | evtAddrParitySec;
        rawEvt[CAUSE_POSTED_PARITY] = evtPostedDataParity;
        rawEvt[CAUSE_POSTED_NODELIVER] = postedIf.limitHit;
        rawEvt[CAUSE_POSTED_TABORT] = evtPostedTargetAbort;
        rawEvt[CAUSE_POSTED_MABORT] = evtPostedMasterAbort;
        rawEvt[CAUSE_DELAYED_WR_NODELIVER] = delayedWrIf.limitHit;
        rawEvt[CAUSE_DELAYED_RD_NODATA] = delayedRdIf.limitHit;
        rawEvt[CAUSE_MASTER_TIMEOUT] = evtDelayedMasterTimeout;
    end

    // the master timeout cause has no mask bit
    assign maskEff = {1'b0, serrMask};
    assign serrCause = rawEvt & ~maskEff & {`CAUSE_COUNT{serrEnable}};
    assign clearBits = statusWr ? cfgWrData[`CAUSE_MSB:`CAUSE_LSB] : '0;
    assign next_serrOut = |serrCause;

    cause_flag_bank #(
        .N(`CAUSE_COUNT)
    ) u_flags (
        .core_clk(core_clk),
        .rst(rst),
        .setBits(serrCause),
        .clearBits(clearBits),
        .flags(flags)
    );

    // register writes with byte lanes
    always_comb begin
        next_opt = opt;
        next_serrMask = serrMask;
        next_retryLimit = retryLimit;
        if (optWr && cfgByteEn[0]) begin
            next_opt.priRdAlias = cfgWrData[`OPT_PRI_RD_ALIAS];
            next_opt.priWrAlias = cfgWrData[`OPT_PRI_WR_ALIAS];
            next_opt.secRdAlias = cfgWrData[`OPT_SEC_RD_ALIAS];
            next_opt.secWrAlias = cfgWrData[`OPT_SEC_WR_ALIAS];
        end
        if (optWr && cfgByteEn[1]) begin
            next_opt.longLock = cfgWrData[`OPT_LONG_LOCK];
            next_opt.secHold = cfgWrData[`OPT_SEC_HOLD];
            next_opt.priHold = cfgWrData[`OPT_PRI_HOLD];
        end
        if (maskWr) begin
            next_serrMask = cfgWrData[`MASK_COUNT-1:0];
        end
        for (int b = 0; b < 4; b++) begin
            if (retryWr && cfgByteEn[b]) begin
                next_retryLimit[b*8 +: 8] = cfgWrData[b*8 +: 8];
            end
        end
    end

    // read data; unmapped offsets and reserved bits return zero
    always_comb begin
        readMux = '0;
        case (cfgAddr)
            `OFS_SERR_STATUS: begin
                readMux[`CAUSE_MSB:`CAUSE_LSB] = flags;
            end
            `OFS_SERR_MASK: begin
                readMux[`MASK_COUNT-1:0] = serrMask;
            end
            `OFS_PORT_OPTION: begin
                readMux[`OPT_PRI_RD_ALIAS] = opt.priRdAlias;
                readMux[`OPT_PRI_WR_ALIAS] = opt.priWrAlias;
                readMux[`OPT_SEC_RD_ALIAS] = opt.secRdAlias;
                readMux[`OPT_SEC_WR_ALIAS] = opt.secWrAlias;
                readMux[`OPT_LONG_LOCK] = opt.longLock;
                readMux[`OPT_SEC_HOLD] = opt.secHold;
                readMux[`OPT_PRI_HOLD] = opt.priHold;
            end
            `OFS_RETRY_LIMIT: begin
                readMux = retryLimit;
            end
            default: begin
                readMux = '0;
            end
        endcase
        next_cfgRdData = cfgRead ? readMux : cfgRdData;
        next_cfgRdValid = cfgRead;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            opt <= '0;
            opt.secHold <= `OPT_SEC_HOLD_RST;
            opt.priHold <= `OPT_PRI_HOLD_RST;
            serrMask <= '0;
            retryLimit <= `RETRY_LIMIT_RST;
            cfgRdData <= '0;
            cfgRdValid <= 1'b0;
            primarySystemErrorOut <= 1'b0;
        end else begin
            opt <= next_opt;
            serrMask <= next_serrMask;
            retryLimit <= next_retryLimit;
            cfgRdData <= next_cfgRdData;
            cfgRdValid <= next_cfgRdValid;
            primarySystemErrorOut <= next_serrOut;
        end
    end

    assign primaryReadAlias = opt.priRdAlias;
    assign primaryWriteAlias = opt.priWrAlias;
    assign secondaryReadAlias = opt.secRdAlias;
    assign secondaryWriteAlias = opt.secWrAlias;
    assign longLockRequest = opt.longLock;
    assign secondaryHoldRequest = opt.secHold;
    assign primaryHoldRequest = opt.priHold;

    sequence optLow;
        optWr && cfgByteEn[0];
    endsequence
    sequence optHigh;
        optWr && cfgByteEn[1];
    endsequence
    sequence clearFlag0;
        statusWr && cfgWrData[`CAUSE_LSB];
    endsequence

    AST_ADDR_PARITY_FLAG: assert property (
        (serrEnable && (evtAddrParityPri || evtAddrParitySec) && !serrMask[0]) |=> flags[0])
        else $error("address parity cause not recorded");
    AST_POSTED_PARITY_FLAG: assert property (
        (serrEnable && evtPostedDataParity && !serrMask[1]) |=> flags[1])
        else $error("posted parity cause not recorded");
    AST_POSTED_NODELIVER_FLAG: assert property (
        (serrEnable && postedIf.limitHit && !serrMask[2]) |=> flags[2])
        else $error("posted non-delivery not recorded");
    AST_TABORT_FLAG: assert property (
        (serrEnable && evtPostedTargetAbort && !serrMask[3]) |=> flags[3])
        else $error("target abort cause not recorded");
    AST_MABORT_FLAG: assert property (
        (serrEnable && evtPostedMasterAbort && !serrMask[4]) |=> flags[4])
        else $error("master abort cause not recorded");
    AST_DW_NODELIVER_FLAG: assert property (
        (serrEnable && delayedWrIf.limitHit && !serrMask[5]) |=> flags[5])
        else $error("delayed write non-delivery not recorded");
    AST_DR_NODATA_FLAG: assert property (
        (serrEnable && delayedRdIf.limitHit && !serrMask[6]) |=> flags[6])
        else $error("delayed read no data not recorded");
    AST_TIMEOUT_FLAG: assert property (
        (serrEnable && evtDelayedMasterTimeout) |=> flags[7] && primarySystemErrorOut)
        else $error("master timeout cause not recorded");
    AST_PRI_RD_ALIAS: assert property (
        optLow |=> primaryReadAlias == $past(cfgWrData[`OPT_PRI_RD_ALIAS]))
        else $error("primary read alias not written");
    AST_PRI_WR_ALIAS: assert property (
        optLow |=> primaryWriteAlias == $past(cfgWrData[`OPT_PRI_WR_ALIAS]))
        else $error("primary write alias not written");
    AST_SEC_RD_ALIAS: assert property (
        optLow |=> secondaryReadAlias == $past(cfgWrData[`OPT_SEC_RD_ALIAS]))
        else $error("secondary read alias not written");
    AST_SEC_WR_ALIAS: assert property (
        optLow |=> secondaryWriteAlias == $past(cfgWrData[`OPT_SEC_WR_ALIAS]))
        else $error("secondary write alias not written");
    AST_LONG_LOCK: assert property (
        optHigh |=> longLockRequest == $past(cfgWrData[`OPT_LONG_LOCK]))
        else $error("long lock option not written");
    AST_SEC_HOLD: assert property (
        optHigh |=> secondaryHoldRequest == $past(cfgWrData[`OPT_SEC_HOLD]))
        else $error("secondary hold option not written");
    AST_PRI_HOLD: assert property (
        optHigh |=> primaryHoldRequest == $past(cfgWrData[`OPT_PRI_HOLD]))
        else $error("primary hold option not written");
    AST_RESERVED_ZERO: assert property (
        (cfgRead && cfgAddr == `OFS_PORT_OPTION) |=> cfgRdValid && !cfgRdData[0]
            && cfgRdData[8:5] == 4'h0)
        else $error("reserved option bits not zero");
    AST_SERR_MASKED: assert property (
        (!serrEnable || (rawEvt & ~maskEff) == '0) |=> !primarySystemErrorOut)
        else $error("error output without enabled unmasked cause");
    AST_RETRY_WRITE: assert property (
        (retryWr && cfgByteEn == 4'hF) |=> retryLimit == $past(cfgWrData))
        else $error("retry limit not written");
    AST_SET_BEATS_CLEAR: assert property (
        (clearFlag0 and serrCause[0]) |=> flags[0])
        else $error("event lost under clearing write");
    AST_ZERO_WRITE_KEEPS: assert property (
        (flags[0] && !(statusWr && cfgWrData[`CAUSE_LSB])) |=> flags[0] [*1])
        else $error("flag lost without clearing write");
endmodule : serr_cause_and_port_options

// ---- test/tb_serr_cause_and_port_options.sv ----
`timescale 1ns/1ps

module tb_serr_cause_and_port_options;
    import serr_cause_pkg::*;

    logic core_clk, rst, cfgWrite, cfgRead, cfgRdValid, serrEnable, primarySystemErrorOut;
    logic [3:0] cfgByteEn;
    cfg_addr_t cfgAddr;
    word_t cfgWrData, cfgRdData, retryLimit, flagsExp;
    logic [5:0] evt;
    logic [2:0] att, dn;
    logic [6:0] opts;
    int n_mismatch, comparisons, cycles, hits;

    serr_cause_and_port_options u_dut (
        .core_clk(core_clk), .rst(rst), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .serrEnable(serrEnable),
        .evtAddrParityPri(evt[0]), .evtAddrParitySec(evt[1]), .evtPostedDataParity(evt[2]),
        .evtPostedTargetAbort(evt[3]), .evtPostedMasterAbort(evt[4]),
        .evtDelayedMasterTimeout(evt[5]), .postedAttempt(att[0]), .postedDone(dn[0]),
        .delayedWrAttempt(att[1]), .delayedWrDone(dn[1]), .delayedRdAttempt(att[2]),
        .delayedRdData(dn[2]), .primarySystemErrorOut(primarySystemErrorOut),
        .primaryReadAlias(opts[0]), .primaryWriteAlias(opts[1]),
        .secondaryReadAlias(opts[2]), .secondaryWriteAlias(opts[3]),
        .longLockRequest(opts[4]), .secondaryHoldRequest(opts[5]),
        .primaryHoldRequest(opts[6]), .retryLimit(retryLimit)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task results;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end

    task check(input word_t seen, input word_t exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task tick;
        @(posedge core_clk);
        #1;
    endtask : tick

    // an idle edge first, so back-to-back calls never lower and raise a strobe at once
    task cfgWr(input cfg_addr_t a, input logic [3:0] be, input word_t d);
        tick();
        cfgWrite = 1'b1;
        cfgAddr = a;
        cfgByteEn = be;
        cfgWrData = d;
        tick();
        cfgWrite = 1'b0;
    endtask : cfgWr

    task rdChk(input cfg_addr_t a, input word_t exp);
        tick();
        check(word_t'(cfgRdValid), 32'h0000_0000);
        cfgRead = 1'b1;
        cfgAddr = a;
        tick();
        cfgRead = 1'b0;
        check(word_t'(cfgRdValid), 32'h0000_0001);
        check(cfgRdData, exp);
    endtask : rdChk

    // one event pulse, then the output must equal expOut for one cycle and then read zero
    task fire(input int i, input logic expOut);
        evt[i] = 1'b1;
        tick();
        evt[i] = 1'b0;
        check(word_t'(primarySystemErrorOut), word_t'(expOut));
        tick();
        check(word_t'(primarySystemErrorOut), 32'h0000_0000);
    endtask : fire

    task attempts(input int k, input int n);
        att[k] = 1'b1;
        repeat (n) tick();
        att[k] = 1'b0;
    endtask : attempts

    initial begin
        {cfgWrite, cfgRead, serrEnable, evt, att, dn} = '0;
        cfgAddr = '0;
        cfgByteEn = '0;
        cfgWrData = '0;
        rst = 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        rst = 1'b0;
        check(word_t'(opts), 32'h0000_0060);
        rdChk(8'h68, 32'h0000_0000);
        rdChk(8'h74, 32'h0000_0C00);
        rdChk(8'h78, 32'h0100_0000);
        check(retryLimit, 32'h0100_0000);
        rdChk(8'h6C, 32'h0000_0000);
        cfgWr(8'h70, 4'hF, 32'hFFFF_FFFF);
        rdChk(8'h70, 32'h0000_0000);
        // option bits: full write, partial lane, then clear
        cfgWr(8'h74, 4'hF, 32'hFFFF_FFFF);
        check(word_t'(opts), 32'h0000_007F);
        rdChk(8'h74, 32'h0000_0E1E);
        cfgWr(8'h74, 4'h1, 32'h0000_0000);
        rdChk(8'h74, 32'h0000_0E00);
        cfgWr(8'h74, 4'hF, 32'h0000_0000);
        check(word_t'(opts), 32'h0000_0000);
        // each direct cause sets its flag and pulses the output
        serrEnable = 1'b1;
        for (int i = 0; i < 6; i++) begin
            fire(i, 1'b1);
        end
        flagsExp = 32'h0099_0000 | 32'h0002_0000;
        rdChk(8'h68, flagsExp);
        cfgWr(8'h68, 4'h4, 32'h0000_0000);
        cfgWr(8'h68, 4'hB, 32'h00FF_0000);
        rdChk(8'h68, flagsExp);
        // set and clear of flags 16 and 19 in the same cycle
        {evt[3], evt[0]} = 2'b11;
        cfgWr(8'h68, 4'h4, 32'h0009_0000);
        {evt[3], evt[0]} = 2'b00;
        rdChk(8'h68, flagsExp);
        cfgWr(8'h68, 4'h4, 32'h00F7_0000);
        rdChk(8'h68, 32'h0008_0000);
        cfgWr(8'h68, 4'h4, 32'h00FF_0000);
        rdChk(8'h68, 32'h0000_0000);
        // masked and disabled events are ignored
        cfgWr(8'h6C, 4'h1, 32'hFFFF_FFFF);
        rdChk(8'h6C, 32'h0000_007F);
        fire(3, 1'b0);
        fire(0, 1'b0);
        fire(5, 1'b1);
        cfgWr(8'h6C, 4'h1, 32'h0000_0000);
        serrEnable = 1'b0;
        fire(4, 1'b0);
        rdChk(8'h68, 32'h0080_0000);
        cfgWr(8'h68, 4'h4, 32'h00FF_0000);
        serrEnable = 1'b1;
        // retry limit shortened to three attempts
        cfgWr(8'h78, 4'hF, 32'h0000_0003);
        check(retryLimit, 32'h0000_0003);
        rdChk(8'h78, 32'h0000_0003);
        for (int k = 0; k < 3; k++) begin
            attempts(k, 2);
            dn[k] = 1'b1;
            tick();
            dn[k] = 1'b0;
            attempts(k, 2);
            hits = 0;
            repeat (4) begin
                hits += int'(primarySystemErrorOut === 1'b1);
                tick();
            end
            check(hits, 0);
            attempts(k, 1);
            repeat (4) begin
                hits += int'(primarySystemErrorOut === 1'b1);
                tick();
            end
            check(hits, 1);
            flagsExp = (k == 0) ? 32'h0004_0000 : (k == 1) ? 32'h0020_0000 : 32'h0040_0000;
            rdChk(8'h68, flagsExp);
            cfgWr(8'h68, 4'h4, 32'h00FF_0000);
        end
        rdChk(8'h68, 32'h0000_0000);
        // reset in mid-run restores every default
        cfgWr(8'h74, 4'hF, 32'h0000_0E1E);
        check(word_t'(opts), 32'h0000_007F);
        fire(2, 1'b1);
        rst = 1'b1;
        tick();
        rst = 1'b0;
        check(word_t'(opts), 32'h0000_0060);
        check(retryLimit, 32'h0100_0000);
        rdChk(8'h68, 32'h0000_0000);
        rdChk(8'h74, 32'h0000_0C00);
        results();
    end
endmodule : tb_serr_cause_and_port_options
